// *** logic/stt_defines.svh ***
// Offsets, field positions, reset values and timing counts of the timer
`ifndef STT_DEFINES_SVH
`define STT_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define STT_OFF_MODE 8'h00
`define STT_OFF_ALARM 8'h04
`define STT_OFF_COUNT 8'h08
`define STT_OFF_FLAGS 8'h0C

// ==========================================================
// Field positions
`define STT_DIV_MSB 15
`define STT_DIV_LSB 0
`define STT_ALARM_IE_BIT 16
`define STT_TICK_IE_BIT 17
`define STT_RESTART_BIT 18
`define STT_ALARM_FLAG_BIT 0
`define STT_TICK_FLAG_BIT 1

// ==========================================================
// Reset values
`define STT_MODE_RST 32'h0000_8000
`define STT_ALARM_RST 32'hFFFF_FFFF
`define STT_COUNT_RST 32'h0000_0000
`define STT_FLAGS_RST 2'h0

// ==========================================================
// Timing: low-frequency clock period and derived enable divider
`define STT_CLK_PERIOD_NS 10
`define STT_SLOW_PERIOD_NS 30518
`define STT_SLOW_DIV_CYC (`STT_SLOW_PERIOD_NS / `STT_CLK_PERIOD_NS)
`define STT_SYNC_SLOW_TICKS 2
`define STT_ZERO_DIV_PERIOD 17'h1_0000

`endif

// *** logic/stt_pkg.sv ***
// Types shared by the seconds timebase timer modules
package stt_pkg;

  // ==========================================================
  // Basic types
  typedef logic [31:0] stt_word_t;
  typedef logic [7:0] stt_addr_t;
  typedef logic [3:0] stt_sel_t;

  // Register selected by a bus access
  typedef enum logic [2:0] {
    STT_REG_MODE,
    STT_REG_ALARM,
    STT_REG_COUNT,
    STT_REG_FLAGS,
    STT_REG_NONE
  } stt_reg_t;

endpackage : stt_pkg

// *** logic/stt_bus_if.sv ***
// Register access channel between the bus slave and the timer core
`timescale 1ns/10ps
interface stt_bus_if;
  import stt_pkg::*;

  logic req;
  logic we;
  stt_addr_t addr;
  stt_sel_t sel;
  stt_word_t wdata;
  stt_word_t rdata;

  // Bus slave side issues accesses
  modport slave (output req, output we, output addr, output sel,
                 output wdata, input rdata);
  // Timer core side serves them
  modport core (input req, input we, input addr, input sel,
                input wdata, output rdata);
endinterface : stt_bus_if

// *** logic/stt_wb_slave.sv ***
// Classic Wishbone slave front end of the timer
`timescale 1ns/10ps
module stt_wb_slave (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire stt_pkg::stt_addr_t wb_adr_i,
  input wire stt_pkg::stt_sel_t wb_sel_i,
  input wire stt_pkg::stt_word_t wb_dat_i,
  stt_bus_if.slave bus,
  output stt_pkg::stt_word_t wb_dat_o,
  output logic wb_ack_o
);
  import stt_pkg::*;

  // ==========================================================
  // Access strobe: one cycle per request, none while acking
  assign bus.req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus.we = wb_we_i;
  assign bus.addr = wb_adr_i;
  assign bus.sel = wb_sel_i;
  assign bus.wdata = wb_dat_i;

  // Acknowledge one cycle after the request, drop it the next
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus.req;
    end
  end

  // Read data captured with the access, held until the next read
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus.req && !wb_we_i) begin
      wb_dat_o <= bus.rdata;
    end
  end

endmodule : stt_wb_slave

// *** logic/stt_timer.sv ***
// Seconds timebase timer: prescaler, elapsed counter, alarm, flags
`timescale 1ns/10ps
`include "stt_defines.svh"

// Summary of operation
// - Counter advances by one whenever the prescaler completes its period, except on a slow tick where a restart applies.
// - Nonzero divider field (mode bits 15:0) sets prescaler period.
// - Divider of zero gives a 65536 slow clock period.
// - Alarm enable (mode bit 16) gates alarm flag onto the interrupt.
// - Tick enable (mode bit 17) gates tick flag onto the interrupt.
// - Writing restart (mode bit 18) reloads and restarts the prescaler.
// - Restart also clears the elapsed counter to zero.
// - Alarm matches when the counter equals alarm value plus one.
// - Count register returns counter value; writes are ignored.
// - Status bit 0 shows an alarm match since last status read.
// - Status bit 1 shows a counter advance since last status read.
// - Status read clears both flags two slow clock cycles later.
// - Restart and count clear take effect two slow cycles later.
module stt_timer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire stt_pkg::stt_addr_t wb_adr_i,
  input wire stt_pkg::stt_sel_t wb_sel_i,
  input wire stt_pkg::stt_word_t wb_dat_i,
  output stt_pkg::stt_word_t wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  import stt_pkg::*;

  // ==========================================================
  // Reset image and user notes

  // Reset word of the mode register, split into fields below
  localparam stt_word_t MODE_RST = `STT_MODE_RST;

  // Any divider value can lose events: a status read clears both
  // flags two slow ticks later, and events in between are cleared too.
  // Restart also waits two slow ticks, so the old count stays visible
  // for up to two slow periods after the write.
  // The bus copy of the count trails the counter by one clock; two
  // reads that straddle an increment differ, so software rereads.
  // The alarm compare runs only at increments, never on a restart.
  // Unmapped offsets read zero and drop writes.

  // ==========================================================
  // Helper functions

  // Prescaler period in slow clock periods for a divider setting
  function automatic logic [16:0] stt_period(input logic [15:0] div);
    logic [16:0] p;
    p = {1'b0, div};
    if (div == 16'h0000) begin
      p = `STT_ZERO_DIV_PERIOD;
    end
    return p;
  endfunction : stt_period

  // Byte-lane merge of a write into a stored word
  function automatic stt_word_t stt_merge(input stt_word_t old_w,
                                          input stt_word_t new_w,
                                          input stt_sel_t sel);
    stt_word_t r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction : stt_merge

  // True on the slow tick that completes a two-tick hand-over
  function automatic logic stt_due(input logic pend, input logic [1:0] ticks,
                                   input logic en);
    logic due;
    due = pend & en & (ticks == 2'(`STT_SYNC_SLOW_TICKS - 1));
    return due;
  endfunction : stt_due

  // ==========================================================
  // Bus front end

  stt_bus_if bus ();

  stt_wb_slave u_slave (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .bus(bus.slave),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o)
  );

  // ==========================================================
  // State declarations

  logic [15:0] div_value;
  logic alarm_ie;
  logic tick_ie;
  stt_word_t alarm_value;
  stt_word_t count;
  logic [16:0] presc;
  logic [11:0] slow_cnt;
  logic slow_en;
  logic restart_pend;
  logic [1:0] restart_ticks;
  logic clear_pend;
  logic [1:0] clear_ticks;
  logic alarm_flag;
  logic tick_flag;
  stt_word_t count_view;
  logic [1:0] flags_view;

  // ==========================================================
  // Address decode

  stt_reg_t reg_sel;
  wire hit_mode = (bus.addr == `STT_OFF_MODE);
  wire hit_alarm = (bus.addr == `STT_OFF_ALARM);
  wire hit_count = (bus.addr == `STT_OFF_COUNT);
  wire hit_flags = (bus.addr == `STT_OFF_FLAGS);

  // Register index, unmapped addresses select none
  assign reg_sel = hit_mode ? STT_REG_MODE :
                   hit_alarm ? STT_REG_ALARM :
                   hit_count ? STT_REG_COUNT :
                   hit_flags ? STT_REG_FLAGS : STT_REG_NONE;

  // Write and read strobes; the count register ignores writes
  wire wr_mode = bus.req & bus.we & (reg_sel == STT_REG_MODE);
  wire wr_alarm = bus.req & bus.we & (reg_sel == STT_REG_ALARM);
  wire rd_flags = bus.req & ~bus.we & (reg_sel == STT_REG_FLAGS);

  // Restart acts on the write itself and is never stored
  // Mode word as stored and as merged with a write
  wire stt_word_t mode_word = {13'h0000, 1'b0, tick_ie, alarm_ie,
                               div_value};
  wire stt_word_t mode_merged = stt_merge(mode_word, bus.wdata, bus.sel);
  wire restart_req = wr_mode & mode_merged[`STT_RESTART_BIT];

  // ==========================================================
  // Read data selection

  wire stt_word_t flags_word = {30'h0000_0000, flags_view};

  // Restart bit always reads zero; unmapped reads return zero
  assign bus.rdata = (reg_sel == STT_REG_MODE) ? mode_word :
                     (reg_sel == STT_REG_ALARM) ? alarm_value :
                     (reg_sel == STT_REG_COUNT) ? count_view :
                     (reg_sel == STT_REG_FLAGS) ? flags_word :
                     32'h0000_0000;

  // ==========================================================
  // Mode register

  // Divider and interrupt enables
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_value <= MODE_RST[`STT_DIV_MSB:`STT_DIV_LSB];
      alarm_ie <= MODE_RST[`STT_ALARM_IE_BIT];
      tick_ie <= MODE_RST[`STT_TICK_IE_BIT];
    end else if (wr_mode) begin
      div_value <= mode_merged[`STT_DIV_MSB:`STT_DIV_LSB];
      alarm_ie <= mode_merged[`STT_ALARM_IE_BIT];
      tick_ie <= mode_merged[`STT_TICK_IE_BIT];
    end
  end

  // ==========================================================
  // Alarm register

  // Alarm value with byte lanes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_value <= `STT_ALARM_RST;
    end else if (wr_alarm) begin
      alarm_value <= stt_merge(alarm_value, bus.wdata, bus.sel);
    end
  end

  // ==========================================================
  // Low-frequency clock enable

  // Stands in for the slow clock: a free-running divider of the clock
  // One-cycle pulse per low-frequency clock period
  wire slow_last = (slow_cnt == 12'(`STT_SLOW_DIV_CYC - 1));

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slow_cnt <= 12'h000;
      slow_en <= 1'b0;
    end else begin
      slow_cnt <= slow_last ? 12'h000 : slow_cnt + 12'h001;
      slow_en <= slow_last;
    end
  end

  // ==========================================================
  // Restart hand-over into the slow domain

  // Restart applies on the second slow edge after the write
  wire restart_go = stt_due(restart_pend, restart_ticks, slow_en);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      restart_pend <= 1'b0;
      restart_ticks <= 2'h0;
    end else if (restart_req) begin
      restart_pend <= 1'b1;
      restart_ticks <= 2'h0;
    end else if (restart_go) begin
      restart_pend <= 1'b0;
      restart_ticks <= 2'h0;
    end else if (restart_pend && slow_en) begin
      restart_ticks <= restart_ticks + 2'h1;
    end
  end

  // ==========================================================
  // Prescaler

  wire [16:0] period = stt_period(div_value);
  wire presc_done = (presc == period - 17'h0_0001);
  wire inc_go = slow_en & ~restart_go & presc_done;

  // Counts slow periods; restart reloads it from the new divider
  wire [16:0] next_presc = restart_go ? 17'h0_0000 :
                           ~slow_en ? presc :
                           presc_done ? 17'h0_0000 : presc + 17'h0_0001;

  // Prescaler register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc <= 17'h0_0000;
    end else begin
      presc <= next_presc;
    end
  end

  // ==========================================================
  // Elapsed-time counter and alarm compare

  // Natural 32-bit overflow wraps the counter to zero
  wire stt_word_t count_inc = count + 32'h0000_0001;
  wire stt_word_t alarm_target = alarm_value + 32'h0000_0001;
  wire alarm_hit = inc_go & (count_inc == alarm_target);

  // Next count: restart clears it, an increment steps it
  wire stt_word_t next_count = restart_go ? `STT_COUNT_RST :
                               inc_go ? count_inc : count;

  // Elapsed-time counter register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= `STT_COUNT_RST;
    end else begin
      count <= next_count;
    end
  end

  // ==========================================================
  // Status clear hand-over into the slow domain

  // Clear applies on the second slow edge after the status read;
  // a further read while a clear is pending starts the wait again
  wire clear_go = stt_due(clear_pend, clear_ticks, slow_en);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_pend <= 1'b0;
      clear_ticks <= 2'h0;
    end else if (rd_flags) begin
      clear_pend <= 1'b1;
      clear_ticks <= 2'h0;
    end else if (clear_go) begin
      clear_pend <= 1'b0;
      clear_ticks <= 2'h0;
    end else if (clear_pend && slow_en) begin
      clear_ticks <= clear_ticks + 2'h1;
    end
  end

  // ==========================================================
  // Sticky event flags

  // A new event in the clearing cycle wins over the clear
  wire next_alarm_flag = alarm_hit | (alarm_flag & ~clear_go);
  wire next_tick_flag = inc_go | (tick_flag & ~clear_go);

  // Flag registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_flag <= 1'b0;
      tick_flag <= 1'b0;
    end else begin
      alarm_flag <= next_alarm_flag;
      tick_flag <= next_tick_flag;
    end
  end

  // ==========================================================
  // Bus-side views of counter and flags

  // Retimed copies read by the bus
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_view <= `STT_COUNT_RST;
      flags_view <= `STT_FLAGS_RST;
    end else begin
      count_view <= count;
      flags_view <= {tick_flag, alarm_flag};
    end
  end

  // ==========================================================
  // Interrupt output

  // Each flag reaches the interrupt only through its enable
  wire alarm_src = alarm_flag & alarm_ie;
  wire tick_src = tick_flag & tick_ie;
  wire next_irq = alarm_src | tick_src;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

endmodule : stt_timer

// *** test/stt_timer_monitor.sv ***
// Port checker of the seconds timebase timer
`timescale 1ns/10ps
`include "stt_defines.svh"
module stt_timer_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire stt_pkg::stt_addr_t wb_adr_i,
  input wire stt_pkg::stt_sel_t wb_sel_i,
  input wire stt_pkg::stt_word_t wb_dat_i,
  input wire stt_pkg::stt_word_t wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o
);
  import stt_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Helper logic
  // Request taken at this edge
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_mode = take && wb_we_i && wb_adr_i == `STT_OFF_MODE;
  logic rd_q;
  stt_addr_t adr_q;
  stt_word_t sh_mode;
  // Shadow of the mode register, read flag of the pending answer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_mode <= `STT_MODE_RST;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (wr_mode && wb_sel_i[b]) sh_mode[8*b +: 8] <= wb_dat_i[8*b +: 8];
      end
      rd_q <= take && !wb_we_i;
      adr_q <= wb_adr_i;
    end
  end
  wire rd_ans = wb_ack_o && rd_q;
  // ==========================================================
  // Assertions
  property p_ack_next; take |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after a request");
  property p_ack_cause; wb_ack_o |-> $past(take); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_mode_rd;
    rd_ans && adr_q == `STT_OFF_MODE |-> wb_dat_o == (sh_mode & 32'h0003_FFFF);
  endproperty
  a_mode_rd: assert property (p_mode_rd)
    else $error("mode read differs from written fields");
  property p_flags_rd;
    rd_ans && adr_q == `STT_OFF_FLAGS |-> wb_dat_o[31:2] == 30'h0;
  endproperty
  a_flags_rd: assert property (p_flags_rd)
    else $error("reserved flag bits set");
  property p_unmapped;
    rd_ans && adr_q > `STT_OFF_FLAGS |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_dat_hold; $changed(wb_dat_o) |-> rd_ans; endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed outside a read answer");
  property p_irq_off;
    wb_ack_o && $past(wr_mode && wb_sel_i[2] && wb_dat_i[17:16] == 2'b00)
      |-> ##2 !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high with both enables off");
  // Main scenarios reached
  c_alarm_rd: cover property (rd_ans && adr_q == `STT_OFF_FLAGS &&
                              wb_dat_o[0]);
  c_irq_rise: cover property ($rose(irq_o));
  c_restart: cover property (wr_mode && wb_dat_i[18]);
endmodule : stt_timer_monitor

// *** test/tb_seconds_timebase_timer.sv ***
// Self-checking bench of the seconds timebase timer
`timescale 1ns/10ps
`include "stt_defines.svh"
module tb_seconds_timebase_timer;
  import stt_pkg::*;
  localparam int TICK = `STT_SLOW_DIV_CYC;
  logic ref_clk_i, rst_i, cyc, stb, we, ack, irq;
  stt_addr_t adr;
  stt_sel_t sel;
  stt_word_t wdat, dat_o, rdat, e, r, r2, c0, c1;
  stt_word_t exp_q[$];
  logic chk_q[$];
  int n_fail, tests_run, cyc_cnt;
  stt_timer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq));
  // Clock source
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic cmp(input stt_word_t got, input stt_word_t ex);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Read answer taken at the edge where ack is seen high
  always @(posedge ref_clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      rdat = dat_o;
      e = exp_q.pop_front();
      if (chk_q.pop_front()) cmp(rdat, e);
    end
  end
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 99000) begin
      n_fail++;
      end_sim();
    end
  end
  // One classic Wishbone cycle; a read notes its expectation
  task automatic bus(input logic w, input stt_addr_t a, input stt_word_t d,
                     input stt_sel_t s, input logic c, input stt_word_t x);
    if (!w) begin
      exp_q.push_back(x);
      chk_q.push_back(c);
    end
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge ref_clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input stt_addr_t a, input stt_word_t d);
    bus(1'b1, a, d, 4'hF, 1'b0, 32'h0);
  endtask
  task automatic chk(input stt_addr_t a, input stt_word_t x);
    bus(1'b0, a, 32'h0, 4'hF, 1'b1, x);
  endtask
  // Count read repeated until two reads agree
  task automatic rd_cnt(output stt_word_t v);
    stt_word_t p;
    bus(1'b0, `STT_OFF_COUNT, 32'h0, 4'hF, 1'b0, 32'h0);
    do begin
      p = rdat;
      bus(1'b0, `STT_OFF_COUNT, 32'h0, 4'hF, 1'b0, 32'h0);
    end while (rdat !== p);
    v = rdat;
  endtask
  task automatic poll(input stt_word_t n);
    do begin
      repeat (500) @(posedge ref_clk_i);
      rd_cnt(c0);
    end while (c0 < n);
  endtask
  task automatic irq_is(input logic v);
    repeat (4) @(posedge ref_clk_i);
    cmp({31'h0, irq}, {31'h0, v});
  endtask
  // Main sequence
  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    rst_i = 1'b1;
    void'($urandom(32'h916A0BDE));
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(`STT_OFF_MODE, `STT_MODE_RST);
    chk(`STT_OFF_ALARM, `STT_ALARM_RST);
    chk(`STT_OFF_COUNT, `STT_COUNT_RST);
    chk(`STT_OFF_FLAGS, 32'h0);
    chk(8'h10, 32'h0);
    $display("Test reset values done");
    r = $urandom();
    r2 = $urandom();
    wr(`STT_OFF_ALARM, r);
    chk(`STT_OFF_ALARM, r);
    bus(1'b1, `STT_OFF_ALARM, r2, 4'h2, 1'b0, 32'h0);
    chk(`STT_OFF_ALARM, {r[31:16], r2[15:8], r[7:0]});
    wr(`STT_OFF_ALARM, 32'h2);
    wr(`STT_OFF_MODE, 32'h0005_0001);
    chk(`STT_OFF_MODE, 32'h0001_0001);
    $display("Test register access done");
    poll(2);
    cmp(c0, 32'h2);
    irq_is(1'b0);
    poll(3);
    irq_is(1'b1);
    wr(`STT_OFF_MODE, 32'h0000_0001);
    irq_is(1'b0);
    wr(`STT_OFF_MODE, 32'h0002_0001);
    irq_is(1'b1);
    chk(`STT_OFF_FLAGS, 32'h3);
    repeat (4 * TICK) @(posedge ref_clk_i);
    chk(`STT_OFF_FLAGS, 32'h2);
    $display("Test alarm and flags done");
    rd_cnt(c0);
    // Start just after an increment so the window spans whole periods
    do rd_cnt(c1); while (c1 == c0);
    wr(`STT_OFF_COUNT, $urandom());
    repeat (3 * TICK + 100) @(posedge ref_clk_i);
    rd_cnt(c0);
    cmp(c0, c1 + 32'h3);
    wr(`STT_OFF_MODE, 32'h0004_0003);
    rd_cnt(c0);
    cmp({31'h0, c0 != 0}, 32'h1);
    repeat (3 * TICK) @(posedge ref_clk_i);
    rd_cnt(c0);
    cmp(c0, 32'h0);
    repeat (3 * TICK) @(posedge ref_clk_i);
    rd_cnt(c1);
    cmp(c1, c0 + 32'h1);
    $display("Test counting and restart done");
    wr(`STT_OFF_MODE, 32'h0004_0000);
    repeat (4 * TICK) @(posedge ref_clk_i);
    rd_cnt(c0);
    cmp(c0, 32'h0);
    $display("Test zero divider done");
    end_sim();
  end
endmodule : tb_seconds_timebase_timer
bind stt_timer stt_timer_monitor u_mon (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o));
